// ### inc/eep_map.vh
// Constants for the serial memory access logic: sizes, codes, timing.
// Assumes the includer works on the 40 MHz system clock.
`ifndef EEP_MAP_VH
`define EEP_MAP_VH

// Array and page geometry
`define EEP_ADDR_BITS 12
`define EEP_PAGE_BITS 5
`define EEP_PAGE_BYTES 32
`define EEP_PTR_RST 12'h000

// Control byte layout
`define EEP_CTL_TYPE_HI 7
`define EEP_CTL_TYPE_LO 4
`define EEP_CTL_SEL_HI 3
`define EEP_CTL_SEL_LO 1
`define EEP_CTL_RD 0
// Device type code; the value is arbitrary
`define EEP_DEV_TYPE 4'h5

// Timing: system clock period and per-byte write time, in ns
`define EEP_CLK_NS 25
`define EEP_T_BYTE_NS 30000
// Least time, rounded up to whole cycles
`define EEP_T_BYTE_CYC ((`EEP_T_BYTE_NS + `EEP_CLK_NS - 1) / `EEP_CLK_NS)

`endif

// ### logic/eep_ram.v
// Single-port byte memory with a registered read port.
// Assumes one clock; write and read share the address.
module eep_ram #(
  parameter AW = 12, // Address width
  parameter DW = 8 // Data width
) (
  input wire clock, // System clock
  input wire we, // Write strobe
  input wire [AW-1:0] addr, // Word address
  input wire [DW-1:0] wdata, // Write data
  output reg [DW-1:0] rdata // Registered read data
);

  reg [DW-1:0] mem [0:(1<<AW)-1]; // Storage, no reset by design

  // Read first: a write returns the old byte, read data always from a flip-flop
  always @(posedge clock) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule // eep_ram

// ### logic/eep_sync.v
// Pin synchronisers and bus event detection for the serial link.
// Assumes all inputs are asynchronous pins; outputs are on clock.
module eep_sync (
  input wire clock, // System clock
  input wire nrst, // Synchronous reset, active low
  input wire scl, // Serial clock pin
  input wire sda_in, // Serial data pin level
  input wire wp, // Write protect pin
  input wire [2:0] strap, // Chip-select straps
  output wire scl_rise, // Pulse: clock rising edge
  output wire scl_fall, // Pulse: clock falling edge
  output wire start_det, // Pulse: start condition
  output wire stop_det, // Pulse: stop condition
  output wire sda_s, // Synchronised data level
  output wire wp_s, // Synchronised write protect
  output wire [2:0] strap_s // Synchronised straps
);

  reg [5:0] s1; // First stage, read only by second stage
  reg [5:0] s2; // Second stage
  reg scl_d; // Delayed clock for edges
  reg sda_d; // Delayed data for edges

  // Two-flop synchronisers, then one delay stage for edge finding
  always @(posedge clock) begin
    if (!nrst) begin
      s1 <= 6'h3f;
      s2 <= 6'h3f;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      s1 <= {strap, wp, sda_in, scl};
      s2 <= s1;
      scl_d <= s2[0];
      sda_d <= s2[1];
    end
  end

  assign scl_rise = s2[0] & ~scl_d;
  assign scl_fall = ~s2[0] & scl_d;
  // Data moving while the clock stays high marks start or stop
  assign start_det = s2[0] & scl_d & ~s2[1] & sda_d;
  assign stop_det = s2[0] & scl_d & s2[1] & ~sda_d;
  assign sda_s = s2[1];
  assign wp_s = s2[2];
  assign strap_s = s2[5:3];

endmodule // eep_sync

// ### logic/eep_core.v
// Access logic of a two-wire serial memory slave: page writes through
// a page buffer, write protect, busy polling and the three read kinds.
// Assumes SCL and SDA arrive as raw pins, SCL far slower than clock.
`include "eep_map.vh"

module eep_core #(
  parameter [3:0] DEV_TYPE = `EEP_DEV_TYPE, // Arbitrary type code
  parameter [15:0] T_BYTE_CYC = `EEP_T_BYTE_CYC // Cycles per byte
) (
  input wire clock, // System clock, 40 MHz
  input wire nrst, // Synchronous reset, active low
  input wire scl, // Serial clock pin
  input wire sda_in, // Serial data pin level
  output wire sda_out, // Serial data drive value, always low
  output reg sda_oe, // High while pulling data low
  input wire wp, // Write protect pin
  input wire chip_select_strap_bit0, // Select strap 0
  input wire chip_select_strap_bit1, // Select strap 1
  input wire chip_select_strap_bit2, // Select strap 2
  output wire write_busy // High during internal write cycle
);

  // Geometry from the map header; the bench hard-codes its own
  localparam AW = `EEP_ADDR_BITS;
  localparam PW = `EEP_PAGE_BITS;

  // One-hot states
  localparam [6:0] ST_IDLE = 7'h01; // Waiting for start
  localparam [6:0] ST_CTL = 7'h02; // Receiving control byte
  localparam [6:0] ST_AHI = 7'h04; // Receiving high address
  localparam [6:0] ST_ALO = 7'h08; // Receiving low address
  localparam [6:0] ST_WDAT = 7'h10; // Receiving data bytes
  localparam [6:0] ST_RDAT = 7'h20; // Sending data bytes
  localparam [6:0] ST_WCYC = 7'h40; // Internal write cycle

  // Next address inside the same page
  function [AW-1:0] page_inc;
    input [AW-1:0] a;
    begin
      page_inc = {a[AW-1:PW], a[PW-1:0] + {{(PW-1){1'b0}}, 1'b1}};
    end
  endfunction

  wire scl_rise; // Clock edges and bus events
  wire scl_fall;
  wire start_det;
  wire stop_det;
  wire sda_s; // Synchronised pin levels
  wire wp_s;
  wire [2:0] strap_s;

  // Protocol state and byte framing
  reg [6:0] st; // Current state
  reg [3:0] cnt; // Bit count within a byte, 9 is ack slot
  reg [7:0] sh; // Receive shift register
  reg [7:0] tsh; // Transmit shift register
  reg [3:0] ahi; // Upper address bits held until low byte
  reg [AW-1:0] ptr; // Internal address pointer
  reg [AW-1:0] base; // Start address of the page write
  reg [`EEP_PAGE_BYTES-1:0] vmask; // Buffer slots holding data
  reg acked; // Current byte earned our acknowledge
  reg mack; // Master acknowledged the last sent byte
  reg [5:0] k; // Commit slot counter
  reg [1:0] ph; // Commit phase: read, write, wait
  reg [15:0] tmr; // Per-byte write timer

  // Commit addressing: the buffer is read one cycle ahead of the array
  // write, so the array always takes a settled byte
  wire [PW-1:0] cidx = base[PW-1:0] + k[PW-1:0]; // Slot in commit
  wire commit_wr = (st == ST_WCYC) & (ph == 2'd1);
  wire buf_we = scl_fall & (cnt == 4'd8) & (st == ST_WDAT);
  wire [PW-1:0] buf_addr = (st == ST_WCYC) ? cidx : ptr[PW-1:0];
  wire [7:0] buf_q; // Buffered byte for commit
  wire [AW-1:0] mem_addr = commit_wr ? {base[AW-1:PW], cidx} : ptr;
  wire [7:0] mem_q; // Array byte at pointer
  wire sel_ok = (sh[`EEP_CTL_TYPE_HI:`EEP_CTL_TYPE_LO] == DEV_TYPE) &&
    (sh[`EEP_CTL_SEL_HI:`EEP_CTL_SEL_LO] == strap_s);

  // Open-drain data pin: only the enable ever moves
  assign sda_out = 1'b0;
  assign write_busy = (st == ST_WCYC);

  // Pins pass two flip-flops before any decision reads them
  eep_sync u_sync (
    .clock(clock),
    .nrst(nrst),
    .scl(scl),
    .sda_in(sda_in),
    .wp(wp),
    .strap({chip_select_strap_bit2, chip_select_strap_bit1,
      chip_select_strap_bit0}),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det),
    .sda_s(sda_s),
    .wp_s(wp_s),
    .strap_s(strap_s)
  );

  // Page buffer, indexed by page offset so excess bytes overwrite
  eep_ram #(.AW(PW), .DW(8)) u_buf (
    .clock(clock),
    .we(buf_we),
    .addr(buf_addr),
    .wdata(sh),
    .rdata(buf_q)
  );

  // Memory array, reads follow the pointer
  eep_ram #(.AW(AW), .DW(8)) u_arr (
    .clock(clock),
    .we(commit_wr),
    .addr(mem_addr),
    .wdata(buf_q),
    .rdata(mem_q)
  );

  // Protocol and commit state machine
  always @(posedge clock) begin
    // Array contents are left alone by reset
    if (!nrst) begin
      st <= ST_IDLE;
      cnt <= 4'h0;
      sh <= 8'h00;
      tsh <= 8'h00;
      ahi <= 4'h0;
      ptr <= `EEP_PTR_RST;
      base <= `EEP_PTR_RST;
      vmask <= {`EEP_PAGE_BYTES{1'b0}};
      acked <= 1'b0;
      mack <= 1'b0;
      k <= 6'h00;
      ph <= 2'd0;
      tmr <= 16'h0000;
      sda_oe <= 1'b0;
    end else if (st == ST_WCYC) begin
      // Bus is ignored entirely here, so polls go unanswered
      sda_oe <= 1'b0;
      // All slots scanned; empty ones cost one cycle each
      if (k == 6'd32) begin
        st <= ST_IDLE;
      end else if (!vmask[cidx]) begin
        k <= k + 6'd1;
      end else begin
        case (ph)
          2'd0: begin
            // Buffer read address settles this cycle
            ph <= 2'd1;
          end
          2'd1: begin
            // Array takes the byte now, then the byte time runs
            ph <= 2'd2;
            tmr <= T_BYTE_CYC - 16'd1;
          end
          default: begin
            if (tmr == 16'h0000) begin
              ph <= 2'd0;
              k <= k + 6'd1;
            end else begin
              tmr <= tmr - 16'd1;
            end
          end
        endcase
      end
    end else if (start_det) begin
      // Start or restart abandons any write in progress
      st <= ST_CTL;
      cnt <= 4'h0;
      sda_oe <= 1'b0;
      vmask <= {`EEP_PAGE_BYTES{1'b0}};
    end else if (stop_det) begin
      // Stop ends any transfer; only a filled write goes on to commit
      sda_oe <= 1'b0;
      cnt <= 4'h0;
      st <= ST_IDLE;
      // A read that ended with a refused byte moves the pointer here,
      // so the next current read starts after the byte just returned
      if (st == ST_RDAT && !mack) begin
        ptr <= ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (st == ST_WDAT && vmask != {`EEP_PAGE_BYTES{1'b0}}) begin
        // Protect level taken here only, at the stop
        if (!wp_s) begin
          st <= ST_WCYC;
          k <= 6'h00;
          ph <= 2'd0;
        end else begin
          vmask <= {`EEP_PAGE_BYTES{1'b0}};
        end
      end
    // Transmit side: bits change on clock falls, master answers on rises
    end else if (st == ST_RDAT) begin
      if (scl_rise && cnt < 4'd8) begin
        cnt <= cnt + 4'd1;
      end else if (scl_rise && cnt == 4'd8) begin
        // Master answer on the ninth clock
        cnt <= 4'd9;
        mack <= ~sda_s;
        if (!sda_s) begin
          ptr <= ptr + {{(AW-1){1'b0}}, 1'b1};
        end
      end else if (scl_fall && cnt == 4'd8) begin
        sda_oe <= 1'b0; // Release for the master answer
      end else if (scl_fall && cnt == 4'd9) begin
        if (mack) begin
          // Next byte is ready since the pointer moved at the rise
          tsh <= {mem_q[6:0], 1'b0};
          sda_oe <= ~mem_q[7];
          cnt <= 4'h0;
        end else begin
          // Master refused: stay quiet in this state until the stop,
          // which still owes the pointer its last step
          sda_oe <= 1'b0;
        end
      end else if (scl_fall) begin
        sda_oe <= ~tsh[7];
        tsh <= {tsh[6:0], 1'b0};
      end
    // Receive side: control, address and data bytes
    end else if (st != ST_IDLE) begin
      if (scl_rise && cnt < 4'd8) begin
        sh <= {sh[6:0], sda_s};
        cnt <= cnt + 4'd1;
      end else if (scl_fall && cnt == 4'd8) begin
        // Whole byte in: decide the acknowledge
        cnt <= 4'd9;
        acked <= 1'b1;
        sda_oe <= 1'b1;
        case (st)
          ST_CTL: begin
            if (!sel_ok) begin
              acked <= 1'b0;
              sda_oe <= 1'b0;
            end
          end
          ST_AHI: begin
            ahi <= sh[3:0];
          end
          ST_ALO: begin
            ptr <= {ahi, sh};
            base <= {ahi, sh};
            vmask <= {`EEP_PAGE_BYTES{1'b0}};
          end
          default: begin
            // Data byte lands at its page offset; pointer wraps
            vmask[ptr[PW-1:0]] <= 1'b1;
            ptr <= page_inc(ptr);
          end
        endcase
      end else if (scl_fall && cnt == 4'd9) begin
        sda_oe <= 1'b0;
        cnt <= 4'h0;
        case (st)
          ST_CTL: begin
            if (!acked) begin
              st <= ST_IDLE;
            end else if (sh[`EEP_CTL_RD]) begin
              // First byte sent comes from the pointer
              st <= ST_RDAT;
              mack <= 1'b0;
              tsh <= {mem_q[6:0], 1'b0};
              sda_oe <= ~mem_q[7];
            end else begin
              st <= ST_AHI;
            end
          end
          ST_AHI: begin
            st <= ST_ALO;
          end
          default: begin
            st <= ST_WDAT;
          end
        endcase
      end
    end
  end

endmodule // eep_core

// ### bench/eep_core_asserts.sv
// Checker for the serial memory slave: bus answers and write cycle.
// Assumes it is bound to eep_core and sees only that module's ports.
module eep_core_asserts #(
  parameter [15:0] T_BYTE_CYC = 16'd20 // Cycles per committed byte
) (
  input wire clock, // System clock
  input wire nrst, // Reset, active low
  input wire scl, // Serial clock pin
  input wire sda_in, // Data wire level
  input wire sda_out, // Data drive value
  input wire sda_oe, // Data pull enable
  input wire wp, // Write protect pin
  input wire write_busy // Write cycle flag
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sda_q; // Data level one cycle back
  logic wp_stop; // Protect level at the last stop
  logic [7:0] since_stop; // Cycles since a stop on the pins
  logic [11:0] busy_len; // Length of the busy spell so far
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // Stop seen raw on the pins, so the core's own detector is not trusted
  always @(posedge clock) begin
    sda_q <= sda_in;
    busy_len <= write_busy ? busy_len + 12'h001 : 12'h000;
    if (!nrst) begin
      since_stop <= 8'hff;
    end else if (scl && sda_in && !sda_q) begin
      since_stop <= 8'h00;
      wp_stop <= wp;
    end else if (since_stop != 8'hff) begin
      since_stop <= since_stop + 8'h01;
    end
  end
  out_low_a: assert property (sda_out == 1'b0)
    else $error("data drive value not low");
  busy_quiet_a: assert property (write_busy |-> !sda_oe)
    else $error("acknowledge while busy");
  reset_idle_a: assert property (@(posedge clock) disable iff (1'b0)
    !nrst |=> !sda_oe && !write_busy) else $error("not idle in reset");
  busy_cause_a: assert property ($rose(write_busy) |->
    since_stop <= 8'd12) else $error("write cycle without stop");
  prot_skip_a: assert property ($rose(write_busy) |-> !wp_stop)
    else $error("write cycle while protected");
  busy_hold_a: assert property ($rose(write_busy) |-> write_busy[*8])
    else $error("write cycle cut short");
  busy_min_a: assert property ($fell(write_busy) |->
    busy_len >= T_BYTE_CYC) else $error("write cycle below one byte time");
  busy_max_a: assert property (write_busy |->
    busy_len < 32 * (T_BYTE_CYC + 3) + 64) else $error("busy too long");
  ack_hold_a: assert property ($rose(sda_oe) |-> sda_oe[*3])
    else $error("data pull too short");
  cover property ($fell(write_busy));
  cover property ($rose(sda_oe) && !write_busy);
  cover property (wp && $rose(since_stop == 8'h00));
endmodule // eep_core_asserts

bind eep_core eep_core_asserts #(.T_BYTE_CYC(T_BYTE_CYC))
  i_eep_core_asserts (
  .clock(clock), .nrst(nrst), .scl(scl), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .wp(wp), .write_busy(write_busy));

// ### bench/eep_master.sv
// Two-wire bus master model: frames, bytes and acknowledges.
// Assumes the bench calls its tasks; lines move at falling clock edges.
module eep_master (
  input wire clock, // System clock, paces the bits
  input wire sda, // Resolved data wire
  output logic scl, // Serial clock, stands high outside frames
  output logic sda_drv // Data drive, 1 releases to the pull-up
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Half link period: 4 system clocks of the 25 ns period
  task q;
    repeat (4) @(negedge clock);
  endtask
  // One bit; data moves a clock after the fall so it never races it
  task bit_io(input logic b, output logic r);
    @(negedge clock);
    sda_drv = b;
    repeat (3) @(negedge clock);
    scl = 1'b1;
    q;
    r = sda;
    scl = 1'b0;
  endtask
  // Start, also usable as a repeated start
  task start;
    sda_drv = 1'b1;
    q;
    scl = 1'b1;
    q;
    sda_drv = 1'b0;
    q;
    scl = 1'b0;
  endtask
  // Stop leaves both lines high
  task stop;
    q;
    sda_drv = 1'b0;
    q;
    scl = 1'b1;
    q;
    sda_drv = 1'b1;
    q;
  endtask
  // Byte out, MSB first, then listen for the ninth bit
  task wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // Byte in; ack asks for more, no ack ends the read
  task rbyte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!mack, r);
  endtask
endmodule // eep_master

// ### bench/eep_core_tb.sv
// Bench for the serial memory slave: writes, protect, polling, reads.
// Assumes eep_map.vh on the include path and the master model beside it.
`include "eep_map.vh"
module eep_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, nrst, wp, scl, sda_drv, sda, sda_out, sda_oe, write_busy;
  logic ack; // Last acknowledge seen
  logic [7:0] d; // Last byte read
  logic [2:0] strap; // Select straps
  logic [7:0] mem [0:4095]; // Expected array
  int fail_count, comparisons, nak;
  // Wired-AND data line with pull-up
  assign sda = sda_drv & ~sda_oe;
  eep_core #(.T_BYTE_CYC(16'd20)) i_eep_core (.clock(clock), .nrst(nrst),
    .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .wp(wp),
    .chip_select_strap_bit0(strap[0]), .chip_select_strap_bit1(strap[1]),
    .chip_select_strap_bit2(strap[2]), .write_busy(write_busy));
  eep_master i_eep_master (.clock(clock), .sda(sda), .scl(scl),
    .sda_drv(sda_drv));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task end_of_test;
    $display("Checks %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function logic [7:0] ctl(input logic rd);
    return {`EEP_DEV_TYPE, strap, rd};
  endfunction
  task wb(input logic [7:0] v, input logic e);
    i_eep_master.wbyte(v, ack);
    chk("ack", {7'h0, ack}, {7'h0, e});
  endtask
  // Control and both address bytes, upper bits zero
  task set_addr(input logic [11:0] a);
    i_eep_master.start;
    wb(ctl(1'b0), 1'b1);
    wb({4'h0, a[11:8]}, 1'b1);
    wb(a[7:0], 1'b1);
  endtask
  // Page write of n bytes base, base+1 ...; model updated when allowed
  task wr_page(input logic [11:0] a, input int n, input logic [7:0] base);
    set_addr(a);
    for (int i = 0; i < n; i++) begin
      wb(base + i[7:0], 1'b1);
      if (!wp) mem[{a[11:5], a[4:0] + i[4:0]}] = base + i[7:0];
    end
    i_eep_master.stop;
  endtask
  // Repeat start and write control byte until acknowledged
  task poll;
    nak = 0;
    ack = 1'b0;
    while (!ack && nak < 100) begin
      i_eep_master.start;
      i_eep_master.wbyte(ctl(1'b0), ack);
      if (!ack) nak++;
    end
    i_eep_master.stop;
    chk("poll ack", {7'h0, ack}, 8'h01);
  endtask
  // Read n bytes from a, random when rnd is set, else at the pointer
  task rd_seq(input logic [11:0] a, input logic rnd, input int n);
    if (rnd) set_addr(a);
    i_eep_master.start;
    wb(ctl(1'b1), 1'b1);
    for (int i = 0; i < n; i++) begin
      i_eep_master.rbyte(i < n - 1, d);
      chk("data", d, mem[a + i[11:0]]);
    end
    i_eep_master.stop;
  endtask
  // Each wrong strap bit and the lowest type bit must go unanswered
  task t_select;
    for (int k = 0; k < 4; k++) begin
      i_eep_master.start;
      wb(ctl(1'b0) ^ (8'h02 << k), 1'b0);
      i_eep_master.stop;
    end
    $display("t_select done");
  endtask
  // 34 bytes from offset 30: wraps in page, buffer overwrites first two
  task t_page;
    wr_page(12'h01e, 34, 8'h40);
    poll;
    chk("busy refusals", {7'h0, nak > 0}, 8'h01);
    rd_seq(12'h000, 1'b1, 32);
    $display("t_page done");
  endtask
  // Read across the top address, then one current read from the pointer
  task t_roll;
    wr_page(12'hffe, 2, 8'h90);
    poll;
    rd_seq(12'hffe, 1'b1, 4);
    rd_seq(12'h002, 1'b0, 1);
    $display("t_roll done");
  endtask
  // Protected write: no cycle, pointer still moves within the page
  task t_prot;
    wp = 1'b1;
    wr_page(12'h01f, 3, 8'hc0);
    wp = 1'b0;
    chk("busy", {7'h0, write_busy}, 8'h00);
    poll;
    chk("poll refusals", nak[7:0], 8'h00);
    rd_seq(12'h002, 1'b0, 2);
    rd_seq(12'h000, 1'b1, 2);
    $display("t_prot done");
  endtask
  initial begin
    repeat (60000) @(posedge clock);
    fail_count++;
    $display("Watchdog expired");
    end_of_test;
  end
  initial begin
    nrst = 1'b0;
    wp = 1'b0;
    strap = 3'b101;
    repeat (3) @(negedge clock);
    nrst = 1'b1;
    repeat (4) @(negedge clock);
    t_select;
    t_page;
    t_roll;
    t_prot;
    end_of_test;
  end
endmodule // eep_core_tb
